// [verilog/lps_pkg.sv]
// Purpose: shared constants for the light and proximity sensor core
// Assumes: 40 MHz core clock, registers reached through the serial slave pins
// Notes: register offsets are byte addresses on the serial link
package lps_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h4A;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_LIGHT_CTRL = 8'h02;
  localparam logic [7:0] REG_LIGHT_LO = 8'h03;
  localparam logic [7:0] REG_LIGHT_HI = 8'h04;
  localparam logic [7:0] REG_LHTH_LO = 8'h05;
  localparam logic [7:0] REG_LHTH_HI = 8'h06;
  localparam logic [7:0] REG_LLTH_LO = 8'h07;
  localparam logic [7:0] REG_LLTH_HI = 8'h08;
  localparam logic [7:0] REG_PROX_CTRL = 8'h09;
  localparam logic [7:0] REG_PROX_DATA = 8'h0A;
  localparam logic [7:0] REG_PROX_HTH = 8'h0B;
  localparam logic [7:0] REG_PROX_LTH = 8'h0C;
  localparam logic [7:0] REG_PROX_DRIVE = 8'h0D;
  localparam logic [7:0] REG_UV_DATA = 8'h0E;
  localparam logic [7:0] REG_SOFT_RESET = 8'h5B;
  localparam logic [7:0] REG_PROX_OFFSET = 8'hA5;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hB5;
  localparam logic [7:0] PROX_OFFSET_RESET = 8'h28;
  localparam int STAT_LIGHT_INT_BIT = 3;
  localparam int STAT_PROX_INT_BIT = 2;
  localparam int MODE_PROX_EN_BIT = 1;
  localparam int MODE_UV_EN_BIT = 2;
  localparam int MODE_LIGHT_EN_LSB = 3;
  localparam int CTRL_MANUAL_BIT = 7;
  localparam int PROX_MEASURE_OS_BIT = 7;
  localparam logic [15:0] LIGHT_MAX_AUTO = 16'hFFFF;
  localparam logic [15:0] LIGHT_MAX_MANUAL = 16'h0FFF;
  localparam int CLK_HZ = 40000000;
  localparam int PULSE_MIN_NS = 50000;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int STEP_CYC = 16;
  typedef enum logic [2:0] {
    LPS_IDLE, LPS_START, LPS_PROX, LPS_UV, LPS_WAIT, LPS_LIGHT
  } lps_seq_e;
endpackage : lps_pkg

// [verilog/lps_i2c_slave.sv]
// Purpose: serial two-wire slave byte engine for register access
// Assumes: scl and sda already passed two flip-flops
// Notes: pointer auto-increments on reads; write strobe is one cycle
`timescale 1ns/1ps
`default_nettype none
module lps_i2c_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n_out,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic rd_adv_out,
  input wire logic [7:0] rdata_in
);
  typedef enum logic [2:0] {
    LPS_I_IDLE, LPS_I_DEV, LPS_I_ACK, LPS_I_REG, LPS_I_DATA, LPS_I_SEND, LPS_I_MACK
  } lps_i2c_e;
  typedef struct packed {
    lps_i2c_e st;
    logic scl;
    logic sda;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic have_reg;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr;
    logic adv;
    logic drive;
    lps_i2c_e after_ack;
  } lps_i2c_s;
  lps_i2c_s q, d;
  logic rise, fall, start_c, stop_c;
  always_comb begin
    rise = scl_in & ~q.scl;
    fall = ~scl_in & q.scl;
    start_c = scl_in & q.scl & q.sda & ~sda_in;
    stop_c = scl_in & q.scl & ~q.sda & sda_in;
    d = q;
    d.scl = scl_in;
    d.sda = sda_in;
    d.wr = 1'b0;
    d.adv = 1'b0;
    if (start_c) begin
      d.st = LPS_I_DEV;
      d.cnt = 4'h0;
      d.drive = 1'b0;
    end else if (stop_c) begin
      d.st = LPS_I_IDLE;
      d.drive = 1'b0;
    end else begin
      case (q.st)
        LPS_I_IDLE: d.drive = 1'b0;
        LPS_I_DEV, LPS_I_REG, LPS_I_DATA: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda_in};
            d.cnt = q.cnt + 4'h1;
          end
          if (fall && q.cnt == 4'h8) begin
            d.cnt = 4'h0;
            if (q.st == LPS_I_DEV) begin
              if (q.sh[7:1] == lps_pkg::SLAVE_ADDR) begin
                d.rd = q.sh[0];
                d.drive = 1'b1;
                d.after_ack = q.sh[0] ? LPS_I_SEND : LPS_I_REG;
                d.st = LPS_I_ACK;
              end else begin
                d.st = LPS_I_IDLE;
              end
            end else if (q.st == LPS_I_REG) begin
              d.ptr = q.sh;
              d.drive = 1'b1;
              d.after_ack = LPS_I_DATA;
              d.st = LPS_I_ACK;
            end else begin
              d.wdata = q.sh;
              d.wr = 1'b1;
              d.drive = 1'b1;
              d.after_ack = LPS_I_DATA;
              d.st = LPS_I_ACK;
            end
          end
        end
        LPS_I_ACK: begin
          if (fall) begin
            d.st = q.after_ack;
            d.drive = 1'b0;
            if (q.after_ack == LPS_I_SEND) begin
              d.sh = rdata_in;
              d.drive = ~rdata_in[7];
              d.cnt = 4'h1;
            end
            if (q.after_ack == LPS_I_DATA && q.wr == 1'b0 && q.st == LPS_I_ACK)
              d.ptr = q.ptr;
          end
        end
        LPS_I_SEND: begin
          if (fall) begin
            if (q.cnt == 4'h8) begin
              d.drive = 1'b0;
              d.st = LPS_I_MACK;
              d.ptr = q.ptr + 8'h01;
              d.adv = 1'b1;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.drive = ~q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        LPS_I_MACK: begin
          if (rise && sda_in) d.st = LPS_I_IDLE;
          else if (rise) d.after_ack = LPS_I_SEND;
          if (fall && q.after_ack == LPS_I_SEND) begin
            d.st = LPS_I_SEND;
            d.sh = rdata_in;
            d.drive = ~rdata_in[7];
            d.cnt = 4'h1;
          end
        end
        default: d.st = LPS_I_IDLE;
      endcase
    end
    if (q.st == LPS_I_MACK && rise) d.after_ack = sda_in ? LPS_I_IDLE : LPS_I_SEND;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= LPS_I_IDLE;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
      q.after_ack <= LPS_I_IDLE;
    end else begin
      q <= d;
    end
  end
  assign sda_oe_n_out = ~q.drive;
  assign wr_out = q.wr;
  assign addr_out = q.ptr;
  assign wdata_out = q.wdata;
  assign rd_adv_out = q.adv;
endmodule : lps_i2c_slave
`default_nettype wire

// [verilog/lps_core.sv]
// Purpose: digital core of a light, uv and proximity sensor with serial register access
// Assumes: analogue front ends deliver raw results on ports with a done pulse
// Notes: serial pins pass a two-flop synchroniser before any logic
`timescale 1ns/1ps
`default_nettype none
module lps_core (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic int_n_out,
  output logic int_oe_n_out,
  output logic laser_drive_pin_out,
  output logic [3:0] laser_current_out,
  output logic [3:0] laser_spectrum_out,
  output logic light_start_out,
  output logic light_manual_out,
  output logic uv_start_out,
  output logic prox_start_out,
  input wire logic meas_done_in,
  input wire logic [15:0] light_raw_in,
  input wire logic [7:0] uv_raw_in,
  input wire logic [7:0] prox_raw_in
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    lps_pkg::lps_seq_e seq;
    logic [7:0] mode;
    logic [7:0] lctrl;
    logic [15:0] light;
    logic [15:0] lhth;
    logic [15:0] llth;
    logic [7:0] pctrl;
    logic [7:0] prox;
    logic [7:0] phth;
    logic [7:0] plth;
    logic [7:0] drive;
    logic [7:0] uv;
    logic [7:0] offset;
    logic light_int;
    logic prox_int;
    logic [1:0] lpers;
    logic [1:0] ppers;
    logic busy;
    logic [17:0] tmr;
    logic laser;
  } lps_core_s;
  lps_core_s q, d;
  logic wr, adv;
  logic [7:0] waddr, wdata, rdata;
  logic [16:0] prox_sub;
  logic [15:0] light_clamped;
  logic [17:0] pulse_cyc;
  logic light_on, prox_on, uv_on;
  // ****************************************************************
  // serial slave
  // ****************************************************************
  lps_i2c_slave u_slave (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .scl_in(q.scl_s[1]),
    .sda_in(q.sda_s[1]),
    .sda_oe_n_out(sda_oe_n_out),
    .wr_out(wr),
    .addr_out(waddr),
    .wdata_out(wdata),
    .rd_adv_out(adv),
    .rdata_in(rdata)
  );
  assign sda_out = 1'b0;
  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    case (waddr)
      lps_pkg::REG_STATUS: rdata = {4'h0, q.light_int, q.prox_int, 2'b00};
      lps_pkg::REG_MODE: rdata = q.mode;
      lps_pkg::REG_LIGHT_CTRL: rdata = q.lctrl;
      lps_pkg::REG_LIGHT_LO: rdata = q.light[7:0];
      lps_pkg::REG_LIGHT_HI: rdata = q.light[15:8];
      lps_pkg::REG_LHTH_LO: rdata = q.lhth[7:0];
      lps_pkg::REG_LHTH_HI: rdata = q.lhth[15:8];
      lps_pkg::REG_LLTH_LO: rdata = q.llth[7:0];
      lps_pkg::REG_LLTH_HI: rdata = q.llth[15:8];
      lps_pkg::REG_PROX_CTRL: rdata = q.pctrl;
      lps_pkg::REG_PROX_DATA: rdata = q.prox;
      lps_pkg::REG_PROX_HTH: rdata = q.phth;
      lps_pkg::REG_PROX_LTH: rdata = q.plth;
      lps_pkg::REG_PROX_DRIVE: rdata = q.drive;
      lps_pkg::REG_UV_DATA: rdata = q.uv;
      lps_pkg::REG_PROX_OFFSET: rdata = q.offset;
      default: rdata = 8'h00;
    endcase
  end
  // ****************************************************************
  // datapath helpers
  // ****************************************************************
  always_comb begin
    light_on = q.mode[lps_pkg::MODE_LIGHT_EN_LSB +: 2] != 2'b00;
    prox_on = q.mode[lps_pkg::MODE_PROX_EN_BIT];
    uv_on = q.mode[lps_pkg::MODE_UV_EN_BIT];
    // offset removed, then stretched back to full scale so thresholds keep meaning
    if (prox_raw_in <= q.offset || q.pctrl[lps_pkg::PROX_MEASURE_OS_BIT]) begin
      prox_sub = {9'h000, q.pctrl[lps_pkg::PROX_MEASURE_OS_BIT] ? prox_raw_in : 8'h00};
    end else begin
      prox_sub = 17'(({9'h000, prox_raw_in - q.offset} * 17'd255)
        / {9'h000, 8'hFF - q.offset});
    end
    if (q.lctrl[lps_pkg::CTRL_MANUAL_BIT] && light_raw_in > lps_pkg::LIGHT_MAX_MANUAL)
      light_clamped = lps_pkg::LIGHT_MAX_MANUAL;
    else
      light_clamped = light_raw_in;
    // longest pulse is the minimum shifted by seven, so the count needs eighteen bits
    pulse_cyc = 18'(lps_pkg::PULSE_MIN_CYC) << q.pctrl[6:4];
  end
  // ****************************************************************
  // sequencer and registers
  // ****************************************************************
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], scl_in};
    d.sda_s = {q.sda_s[0], sda_in};
    d.tmr = (q.tmr != 18'h00000) ? q.tmr - 18'h00001 : 18'h00000;
    // the pointer has already stepped past the status byte when the strobe arrives
    if (adv && waddr == 8'(lps_pkg::REG_STATUS + 8'h01)) begin
      d.light_int = 1'b0;
      d.prox_int = 1'b0;
    end
    case (q.seq)
      lps_pkg::LPS_IDLE: begin
        if (light_on || prox_on || uv_on) d.seq = lps_pkg::LPS_START;
      end
      lps_pkg::LPS_START: begin
        if (uv_on) d.seq = lps_pkg::LPS_UV;
        else if (prox_on) d.seq = lps_pkg::LPS_PROX;
        else d.seq = lps_pkg::LPS_WAIT;
        d.busy = 1'b0;
      end
      lps_pkg::LPS_PROX: begin
        if (!q.busy) begin
          d.busy = 1'b1;
          d.laser = 1'b1;
          d.tmr = pulse_cyc;
        end else if (q.laser && q.tmr == 18'h00000) begin
          d.laser = 1'b0;
        end else if (!q.laser && meas_done_in) begin
          d.prox = prox_sub[7:0];
          if (prox_sub[7:0] > q.phth || prox_sub[7:0] < q.plth) begin
            if (q.ppers == q.pctrl[1:0]) d.prox_int = 1'b1;
            else d.ppers = q.ppers + 2'b01;
          end else begin
            d.ppers = 2'b00;
          end
          d.busy = 1'b0;
          d.seq = uv_on ? lps_pkg::LPS_UV : lps_pkg::LPS_WAIT;
        end
      end
      lps_pkg::LPS_UV: begin
        if (!q.busy) d.busy = 1'b1;
        else if (meas_done_in) begin
          d.uv = uv_raw_in;
          d.busy = 1'b0;
          d.seq = uv_on ? lps_pkg::LPS_START : lps_pkg::LPS_WAIT;
        end
      end
      lps_pkg::LPS_WAIT: begin
        if (!q.busy) begin
          d.busy = 1'b1;
          d.tmr = 18'(lps_pkg::STEP_CYC) << q.mode[7:5];
        end else if (q.tmr == 18'h00000) begin
          d.busy = 1'b0;
          d.seq = light_on ? lps_pkg::LPS_LIGHT : lps_pkg::LPS_START;
        end
      end
      lps_pkg::LPS_LIGHT: begin
        if (!q.busy) d.busy = 1'b1;
        else if (meas_done_in) begin
          d.light = light_clamped;
          if (light_clamped > q.lhth || light_clamped < q.llth) begin
            if (q.lpers == q.lctrl[1:0]) d.light_int = 1'b1;
            else d.lpers = q.lpers + 2'b01;
          end else begin
            d.lpers = 2'b00;
          end
          d.busy = 1'b0;
          d.seq = lps_pkg::LPS_START;
        end
      end
      default: d.seq = lps_pkg::LPS_IDLE;
    endcase
    if (wr) begin
      d.seq = lps_pkg::LPS_IDLE;
      d.busy = 1'b0;
      d.laser = 1'b0;
      case (waddr)
        lps_pkg::REG_MODE: d.mode = wdata;
        lps_pkg::REG_LIGHT_CTRL: d.lctrl = wdata;
        lps_pkg::REG_LHTH_LO: d.lhth[7:0] = wdata;
        lps_pkg::REG_LHTH_HI: d.lhth[15:8] = wdata;
        lps_pkg::REG_LLTH_LO: d.llth[7:0] = wdata;
        lps_pkg::REG_LLTH_HI: d.llth[15:8] = wdata;
        lps_pkg::REG_PROX_CTRL: d.pctrl = wdata;
        lps_pkg::REG_PROX_HTH: d.phth = wdata;
        lps_pkg::REG_PROX_LTH: d.plth = wdata;
        lps_pkg::REG_PROX_DRIVE: d.drive = wdata;
        lps_pkg::REG_PROX_OFFSET: d.offset = wdata;
        lps_pkg::REG_SOFT_RESET: begin
          if (wdata == lps_pkg::SOFT_RESET_KEY) begin
            d = '0;
            d.scl_s = q.scl_s;
            d.sda_s = q.sda_s;
            d.seq = lps_pkg::LPS_IDLE;
            d.offset = lps_pkg::PROX_OFFSET_RESET;
          end
        end
        default: d.mode = q.mode;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.scl_s <= 2'b11;
      q.sda_s <= 2'b11;
      q.seq <= lps_pkg::LPS_IDLE;
      q.offset <= lps_pkg::PROX_OFFSET_RESET;
    end else begin
      q <= d;
    end
  end
  // ****************************************************************
  // outputs
  // ****************************************************************
  assign int_n_out = 1'b0;
  assign int_oe_n_out = ~(q.light_int | q.prox_int);
  assign laser_drive_pin_out = q.laser;
  assign laser_current_out = q.drive[7:4];
  assign laser_spectrum_out = q.drive[3:0];
  assign light_start_out = q.seq == lps_pkg::LPS_LIGHT && !q.busy;
  assign light_manual_out = q.lctrl[lps_pkg::CTRL_MANUAL_BIT];
  // uv has no manual path: the range flag is never applied to it
  assign uv_start_out = q.seq == lps_pkg::LPS_UV && !q.busy;
  assign prox_start_out = q.seq == lps_pkg::LPS_PROX && !q.busy;
endmodule : lps_core
`default_nettype wire

// [testbench/lps_core_monitor.sv]
// Purpose: port checker for the sensor core
// Assumes: sees only the top module ports
// Notes: a small slip in sequencing or pin drive trips one of these
`timescale 1ns/1ps
`default_nettype none
module lps_core_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic int_n_out,
  input wire logic int_oe_n_out,
  input wire logic laser_drive_pin_out,
  input wire logic light_start_out,
  input wire logic uv_start_out,
  input wire logic prox_start_out
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int_pin_low_a: assert property (int_n_out == 1'b0)
    else $error("interrupt pin would drive high");
  sda_pin_low_a: assert property (sda_out == 1'b0)
    else $error("data pin would drive high");
  reset_release_a: assert property ($fell(rst_in) |-> int_oe_n_out && sda_oe_n_out && !laser_drive_pin_out)
    else $error("pins not released after reset");
  start_one_cycle_a: assert property (light_start_out |=> !light_start_out)
    else $error("light start longer than one cycle");
  uv_alone_a: assert property (uv_start_out |-> !light_start_out && !prox_start_out)
    else $error("uv start together with another start");
  laser_with_prox_a: assert property (prox_start_out |-> ##[0:1] laser_drive_pin_out)
    else $error("proximity start without laser pulse");
  laser_min_width_a: assert property ($rose(laser_drive_pin_out) |-> laser_drive_pin_out [*8])
    else $error("laser pulse too short");
  int_held_a: assert property ((!int_oe_n_out && $stable(scl_in)) [*8] |=> !int_oe_n_out)
    else $error("interrupt dropped with no bus access");
endmodule : lps_core_monitor
bind lps_core lps_core_monitor i_mon (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out),
  .int_n_out(int_n_out),
  .int_oe_n_out(int_oe_n_out),
  .laser_drive_pin_out(laser_drive_pin_out),
  .light_start_out(light_start_out),
  .uv_start_out(uv_start_out),
  .prox_start_out(prox_start_out)
);
`default_nettype wire

// [testbench/lps_host.sv]
// Purpose: serial bus master model for the sensor core
// Assumes: 200 ns bus clock, changes only at falling core clock edges
// Notes: released data line reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module lps_host (
  input wire logic clk_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_drv_out
);
  // ****************
  // bus cycles
  // ****************
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic q();
    repeat (2) @(negedge clk_in);
  endtask : q
  // clock stands high between frames; also serves as repeated start
  task automatic start();
    sda_drv_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_drv_out = 1'b0;
    q();
    scl_out = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_drv_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_drv_out = 1'b1;
    q();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_drv_out = b;
    q();
    scl_out = 1'b1;
    q();
    r = sda_line_in;
    q();
    scl_out = 1'b0;
    q();
  endtask : bit_io
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask : recv_byte
endmodule : lps_host
`default_nettype wire

// [testbench/light_proximity_sensor_core_test.sv]
// Purpose: self-checking bench for the sensor core
// Assumes: front end answers each start after 20 cycles, after the laser
// Notes: the mode register is written last since any write restarts the sequence
`timescale 1ns/1ps
`default_nettype none
module light_proximity_sensor_core_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl, sda_drv, sda_line, sda_out, sda_oe_n_out, int_n_out, int_oe_n_out, ack;
  logic laser_drive_pin_out, light_manual_out, light_start_out, uv_start_out, prox_start_out;
  logic [3:0] laser_current_out;
  logic [3:0] laser_spectrum_out;
  logic meas_done_in = 1'b0;
  logic [15:0] light_raw_in = 16'h0000;
  logic [7:0] uv_raw_in = 8'h00;
  logic [7:0] prox_raw_in = 8'h00;
  logic [7:0] rb [4];
  int miscompares = 0;
  int n_checks = 0;
  int cnt = 0;
  int n_light = 0;
  int n_uv = 0;
  int n_done = 0;
  always #12.5 clk_in = ~clk_in;
  assign sda_line = sda_drv & (sda_oe_n_out | sda_out);
  lps_core i_dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .int_n_out(int_n_out),
    .int_oe_n_out(int_oe_n_out), .laser_drive_pin_out(laser_drive_pin_out),
    .laser_current_out(laser_current_out), .laser_spectrum_out(laser_spectrum_out),
    .light_start_out(light_start_out), .light_manual_out(light_manual_out),
    .uv_start_out(uv_start_out), .prox_start_out(prox_start_out), .meas_done_in(meas_done_in),
    .light_raw_in(light_raw_in), .uv_raw_in(uv_raw_in), .prox_raw_in(prox_raw_in));
  lps_host i_host (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_drv_out(sda_drv));
  // ****************
  // front end model
  // ****************
  always @(negedge clk_in) begin
    meas_done_in <= 1'b0;
    if (light_start_out) n_light <= n_light + 1;
    if (uv_start_out) n_uv <= n_uv + 1;
    if (light_start_out | uv_start_out | prox_start_out) cnt <= 20;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1 && !laser_drive_pin_out) begin
      cnt <= 0;
      n_done <= n_done + 1;
      meas_done_in <= 1'b1;
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    i_host.start();
    i_host.send_byte(8'h94, ack);
    i_host.send_byte(r, ack);
    i_host.send_byte(d, ack);
    i_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] r, input int n, input logic comb);
    if (comb) begin
      i_host.start();
      i_host.send_byte(8'h94, ack);
      i_host.send_byte(r, ack);
    end
    i_host.start();
    i_host.send_byte(8'h95, ack);
    for (int i = 0; i < n; i++) i_host.recv_byte(rb[i], i == n - 1);
    i_host.stop();
  endtask : rd
  // bounded wait for the next start, then room for its result
  task automatic settle(ref int c);
    int c0;
    c0 = c;
    for (int i = 0; i < 6000 && c == c0; i++) @(negedge clk_in);
    repeat (40) @(negedge clk_in);
  endtask : settle
  task automatic t_reset_vals();
    rd(8'hA5, 1, 1'b1);
    chk(rb[0], 8'h28);
    rd(8'h00, 1, 1'b1);
    chk(rb[0], 8'h00);
  endtask : t_reset_vals
  task automatic t_address();
    i_host.start();
    i_host.send_byte(8'h96, ack);
    i_host.stop();
    chk({7'h00, ack}, 8'h00);
  endtask : t_address
  task automatic t_pointer();
    wr(8'h0C, 8'h11);
    chk({7'h00, ack}, 8'h01);
    wr(8'h0D, 8'h3A);
    chk({laser_current_out, laser_spectrum_out}, 8'h3A);
    rd(8'h0C, 2, 1'b1);
    chk(rb[0], 8'h11);
    chk(rb[1], 8'h3A);
    rd(8'h0B, 1, 1'b1);
    rd(8'h00, 2, 1'b0);
    chk(rb[0], 8'h11);
    chk(rb[1], 8'h3A);
  endtask : t_pointer
  task automatic t_prox();
    int d0;
    prox_raw_in = 8'hC0;
    wr(8'hA5, 8'h00);
    wr(8'h0B, 8'h80);
    wr(8'h09, 8'h01);
    d0 = n_done;
    wr(8'h01, 8'h02);
    for (int i = 0; i < 12000 && int_oe_n_out; i++) @(negedge clk_in);
    chk(8'(n_done - d0), 8'h02);
    wr(8'h01, 8'h00);
    rd(8'h00, 1, 1'b1);
    chk(rb[0] & 8'h0C, 8'h04);
    chk({7'h00, int_oe_n_out}, 8'h01);
    rd(8'h0A, 1, 1'b1);
    chk(rb[0], 8'hC0);
  endtask : t_prox
  // result below the offset reads zero, full scale still reads full scale
  task automatic t_offset();
    prox_raw_in = 8'h30;
    wr(8'hA5, 8'h40);
    wr(8'h01, 8'h02);
    settle(n_done);
    rd(8'h0A, 1, 1'b1);
    chk(rb[0], 8'h00);
    prox_raw_in = 8'hFF;
    wr(8'h01, 8'h02);
    settle(n_done);
    rd(8'h0A, 1, 1'b1);
    chk(rb[0], 8'hFF);
    wr(8'h01, 8'h00);
  endtask : t_offset
  task automatic t_light();
    light_raw_in = 16'h5678;
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h08);
    settle(n_light);
    rd(8'h03, 2, 1'b1);
    chk(rb[0], 8'h78);
    chk(rb[1], 8'h56);
    wr(8'h02, 8'h80);
    settle(n_light);
    chk({7'h00, light_manual_out}, 8'h01);
    rd(8'h03, 2, 1'b1);
    chk(rb[0], 8'hFF);
    chk(rb[1], 8'h0F);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
  endtask : t_light
  task automatic t_uv();
    int l0;
    uv_raw_in = 8'h5A;
    light_raw_in = 16'h1111;
    wr(8'h01, 8'h0C);
    l0 = n_light;
    settle(n_uv);
    settle(n_uv);
    chk(8'(n_light - l0), 8'h00);
    rd(8'h0E, 1, 1'b1);
    chk(rb[0], 8'h5A);
    rd(8'h03, 2, 1'b1);
    chk(rb[1], 8'h0F);
    wr(8'h01, 8'h00);
  endtask : t_uv
  task automatic t_soft_reset();
    wr(8'h5B, 8'hB5);
    rd(8'h0D, 1, 1'b1);
    chk(rb[0], 8'h00);
    chk({laser_current_out, laser_spectrum_out}, 8'h00);
    rd(8'hA5, 1, 1'b1);
    chk(rb[0], 8'h28);
  endtask : t_soft_reset
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_reset_vals();
    t_address();
    t_pointer();
    t_prox();
    t_offset();
    t_light();
    t_uv();
    t_soft_reset();
    tally_and_finish();
  end
  // about four times the expected run
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule : light_proximity_sensor_core_test
`default_nettype wire
